// ==== rtl/cag_core.sv ====
`include "cag_cfg.svh"
`default_nettype none
// Operation
// - 16-bit instruction units; opcode in top four bits; branches carry cc.
// - Address register uses 3-bit code; data register uses 3 or 4 bits.
// - Extension after opcode is 8, 16 or 32 bits of data or address.
// - Register direct picks a 32-bit register, 16-bit half or low-half byte.
// - Register-indirect program address keeps low 24 bits, upper 8 zero.
// - Displacement mode adds sign-extended 16-bit or 32-bit offset to register.
// - Post-increment adds 1, 2 or 4 after access by size.
// - Pre-decrement subtracts 1, 2 or 4 first; result used and written back.
// - 8-bit absolute data address fills upper bits with ones.
// - 16-bit absolute is sign-extended; 32-bit absolute reaches whole space.
// - 24-bit absolute is program address only, upper 8 bits zero.
// - Immediates 8/16/32 bits; 3-bit bit number; 2-bit trap vector field.
// - PC-relative adds sign-extended 8/16-bit offset to next PC, 24 bits.
// - Memory indirect reads longword at 8-bit address 0-255; top byte zero.
// - Odd word, longword or branch address has its low bit forced zero; the memory-indirect longword read address is not.
// - Allowed addressing modes depend on instruction class; others flagged.
// - Low reset pin stops all, masks interrupts; exception on its release.
// - Watchdog overflow enters reset state like the reset pin.
// - Exceptions enter exception state, read the vector, then branch.
// - Bus request releases bus, halts until returned; requester holds it.
// - Sleep instruction or hardware standby enter program-stop state.
module cag_core
	import cag_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic res_n,
	input wire logic wdt_ovf,
	input wire logic exc_req,
	input wire logic [23:0] exc_vec_addr,
	input wire logic bus_req,
	input wire logic sleep_exec,
	input wire logic hw_standby,
	input wire logic dec_valid,
	input wire logic [15:0] op_word,
	input wire logic [31:0] ext_data,
	input wire cag_mode_type ea_mode,
	input wire cag_size_type acc_size,
	input wire cag_class_type instr_class,
	input wire logic [31:0] gpr_rd_data,
	input wire logic [23:0] next_pc,
	input wire logic mem_rvalid,
	input wire logic [31:0] mem_rdata,
	output cag_state_type cpu_state,
	output logic int_mask,
	output logic bus_grant,
	output logic dec_ready,
	output logic ea_valid,
	output logic ea_err,
	output logic ea_is_mem,
	output logic [23:0] ea_addr,
	output logic [31:0] opnd_data,
	output logic [3:0] opcode,
	output logic [3:0] cond_code,
	output logic [2:0] areg_idx,
	output logic [3:0] dreg_idx,
	output logic [2:0] bit_num,
	output logic [1:0] trap_vec,
	output logic wb_en,
	output logic [2:0] wb_idx,
	output logic [31:0] wb_data,
	output logic br_valid,
	output logic [23:0] br_target,
	output logic mem_rd_req,
	output logic [23:0] mem_addr
);

	function automatic logic [23:0] sext8(input logic [7:0] v);
		sext8 = {{16{v[7]}}, v};
	endfunction

	function automatic logic [23:0] sext16(input logic [15:0] v);
		sext16 = {{8{v[15]}}, v};
	endfunction

	function automatic logic [23:0] step_of(input cag_size_type s);
		case (s)
			CAG_SZ_BYTE: step_of = `CAG_STEP_B;
			CAG_SZ_WORD: step_of = `CAG_STEP_W;
			default: step_of = `CAG_STEP_L;
		endcase
	endfunction

	// Odd word/long accesses and branch targets go to the even address below
	function automatic logic [23:0] align(input logic [23:0] a,
		input logic force_even);
		align = force_even ? {a[23:1], 1'b0} : a;
	endfunction

	function automatic logic mode_ok(input cag_class_type c,
		input cag_mode_type m);
		case (c)
			CAG_IC_ALU: mode_ok = (m == CAG_M_REGDIR) || (m == CAG_M_IMM8) ||
				(m == CAG_M_IMM16) || (m == CAG_M_IMM32);
			CAG_IC_XFER: mode_ok = (m != CAG_M_PCREL8) &&
				(m != CAG_M_PCREL16) && (m != CAG_M_MEMIND) &&
				(m != CAG_M_ABS24);
			CAG_IC_BIT: mode_ok = (m == CAG_M_REGDIR) ||
				(m == CAG_M_REGIND) || (m == CAG_M_ABS8) ||
				(m == CAG_M_ABS16) || (m == CAG_M_ABS32);
			default: mode_ok = (m == CAG_M_PCREL8) || (m == CAG_M_PCREL16) ||
				(m == CAG_M_MEMIND) || (m == CAG_M_REGIND) ||
				(m == CAG_M_ABS24);
		endcase
	endfunction

	cag_state_type state_q;
	cag_state_type state_d;
	cag_eafsm_type ea_q;
	logic res_n_q;
	logic [23:0] reg24;
	logic [23:0] step;
	logic [23:0] calc_addr;
	logic [31:0] calc_opnd;
	logic calc_mem;
	logic calc_br;
	logic calc_wb;
	logic [23:0] calc_wbv;
	logic legal;
	logic take;
	logic even_req;

	assign take = dec_valid && dec_ready && (state_q == CAG_ST_EXEC);
	assign reg24 = gpr_rd_data[23:0];
	assign step = step_of(acc_size);
	assign legal = mode_ok(instr_class, ea_mode);

	// Address arithmetic is all 24 bits wide, so sums wrap
	always_comb begin
		calc_addr = `CAG_RST_ADDR;
		calc_opnd = `CAG_RST_DATA;
		calc_mem = 1'b1;
		calc_br = 1'b0;
		calc_wb = 1'b0;
		calc_wbv = reg24;
		case (ea_mode)
			CAG_M_REGDIR: begin
				calc_mem = 1'b0;
				case (acc_size)
					CAG_SZ_BYTE:
						calc_opnd = {24'h000000, op_word[`CAG_DREG_HI] ?
							gpr_rd_data[7:0] : gpr_rd_data[15:8]};
					CAG_SZ_WORD:
						calc_opnd = {16'h0000, op_word[`CAG_DREG_HI] ?
							gpr_rd_data[31:16] : gpr_rd_data[15:0]};
					default: calc_opnd = gpr_rd_data;
				endcase
			end
			CAG_M_REGIND: begin
				calc_addr = reg24;
				calc_br = (instr_class == CAG_IC_BRANCH);
			end
			CAG_M_DISP16: calc_addr = reg24 + sext16(ext_data[15:0]);
			CAG_M_DISP32: calc_addr = reg24 + ext_data[23:0];
			CAG_M_POSTINC: begin
				calc_addr = reg24;
				calc_wb = 1'b1;
				calc_wbv = reg24 + step;
			end
			CAG_M_PREDEC: begin
				calc_addr = reg24 - step;
				calc_wb = 1'b1;
				calc_wbv = reg24 - step;
			end
			CAG_M_ABS8:
				calc_addr = {`CAG_ABS8_FILL, ext_data[7:0]};
			CAG_M_ABS16: calc_addr = sext16(ext_data[15:0]);
			CAG_M_ABS24: begin
				calc_addr = ext_data[23:0];
				calc_br = 1'b1;
			end
			CAG_M_ABS32: calc_addr = ext_data[23:0];
			CAG_M_IMM8: begin
				calc_mem = 1'b0;
				calc_opnd = {24'h000000, ext_data[7:0]};
			end
			CAG_M_IMM16: begin
				calc_mem = 1'b0;
				calc_opnd = {16'h0000, ext_data[15:0]};
			end
			CAG_M_IMM32: begin
				calc_mem = 1'b0;
				calc_opnd = ext_data;
			end
			CAG_M_PCREL8: begin
				calc_mem = 1'b0;
				calc_br = 1'b1;
				calc_addr = next_pc + sext8(op_word[7:0]);
			end
			CAG_M_PCREL16: begin
				calc_mem = 1'b0;
				calc_br = 1'b1;
				calc_addr = next_pc + sext16(ext_data[15:0]);
			end
			default: begin
				calc_addr = {16'h0000, ext_data[7:0]};
			end
		endcase
	end

	assign even_req = calc_br || (acc_size != CAG_SZ_BYTE);

	// Processing-state sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			CAG_ST_RESET:
				if (res_n && !res_n_q) state_d = CAG_ST_EXCEPT;
			CAG_ST_EXCEPT:
				if (mem_rvalid && mem_rd_req) state_d = CAG_ST_EXEC;
			CAG_ST_EXEC:
				if (ea_q == CAG_EA_IDLE && !take) begin
					if (exc_req) state_d = CAG_ST_EXCEPT;
					else if (bus_req) state_d = CAG_ST_BUSREL;
					else if (sleep_exec || hw_standby)
						state_d = CAG_ST_STOP;
				end
			CAG_ST_BUSREL:
				if (!bus_req) state_d = CAG_ST_EXEC;
			CAG_ST_STOP:
				if (exc_req && !hw_standby) state_d = CAG_ST_EXCEPT;
			default: state_d = CAG_ST_RESET;
		endcase
		if (!res_n || wdt_ovf) state_d = CAG_ST_RESET;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_q <= CAG_ST_RESET;
			res_n_q <= 1'b0;
		end else if (ce) begin
			state_q <= state_d;
			res_n_q <= res_n && !wdt_ovf;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cpu_state <= CAG_ST_RESET;
			int_mask <= 1'b1;
			bus_grant <= 1'b0;
		end else if (ce) begin
			cpu_state <= state_d;
			int_mask <= (state_d == CAG_ST_RESET) ||
				(state_d == CAG_ST_EXCEPT && state_q == CAG_ST_RESET) ||
				(int_mask && state_q != CAG_ST_EXEC);
			bus_grant <= (state_d == CAG_ST_BUSREL);
		end
	end

	// Field extraction of the first instruction unit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			opcode <= 4'h0;
			cond_code <= 4'h0;
			areg_idx <= 3'h0;
			dreg_idx <= 4'h0;
			bit_num <= 3'h0;
			trap_vec <= 2'h0;
		end else if (ce && take) begin
			opcode <= op_word[`CAG_OPC_HI:`CAG_OPC_LO];
			cond_code <= op_word[`CAG_CC_HI:`CAG_CC_LO];
			areg_idx <= op_word[`CAG_AREG_HI:`CAG_AREG_LO];
			dreg_idx <= op_word[`CAG_DREG_HI:`CAG_DREG_LO];
			bit_num <= op_word[`CAG_BITN_HI:`CAG_BITN_LO];
			trap_vec <= op_word[`CAG_TRAP_HI:`CAG_TRAP_LO];
		end
	end

	// Effective-address pipeline and indirect fetch
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ea_q <= CAG_EA_IDLE;
			dec_ready <= 1'b0;
			ea_valid <= 1'b0;
			ea_err <= 1'b0;
			ea_is_mem <= 1'b0;
			ea_addr <= `CAG_RST_ADDR;
			opnd_data <= `CAG_RST_DATA;
			wb_en <= 1'b0;
			wb_idx <= 3'h0;
			wb_data <= `CAG_RST_DATA;
			br_valid <= 1'b0;
			br_target <= `CAG_RST_ADDR;
			mem_rd_req <= 1'b0;
			mem_addr <= `CAG_RST_ADDR;
		end else if (ce) begin
			ea_valid <= 1'b0;
			ea_err <= 1'b0;
			wb_en <= 1'b0;
			br_valid <= 1'b0;
			case (ea_q)
				CAG_EA_IDLE: begin
					if (state_d == CAG_ST_EXCEPT && state_q != CAG_ST_EXCEPT) begin
						mem_rd_req <= 1'b1;
						mem_addr <= align(exc_vec_addr, 1'b1);
					end else if (state_q == CAG_ST_EXCEPT && mem_rvalid &&
						mem_rd_req) begin
						mem_rd_req <= 1'b0;
						br_valid <= 1'b1;
						br_target <= align(mem_rdata[23:0], 1'b1);
					end else if (take && !legal) begin
						ea_valid <= 1'b1;
						ea_err <= 1'b1;
					end else if (take && ea_mode == CAG_M_MEMIND) begin
						ea_q <= CAG_EA_INDRD;
						mem_rd_req <= 1'b1;
						mem_addr <= calc_addr;
					end else if (take) begin
						ea_valid <= 1'b1;
						ea_is_mem <= calc_mem && !calc_br;
						ea_addr <= align(calc_addr, even_req);
						opnd_data <= calc_opnd;
						wb_en <= calc_wb;
						wb_idx <= op_word[`CAG_AREG_HI:`CAG_AREG_LO];
						wb_data <= {gpr_rd_data[31:24], calc_wbv};
						br_valid <= calc_br;
						br_target <= align(calc_addr, 1'b1);
					end
				end
				CAG_EA_INDRD: begin
					// Stays here until the longword arrives or reset state is entered; no timeout
					if (mem_rvalid) begin
						ea_q <= CAG_EA_IDLE;
						mem_rd_req <= 1'b0;
						ea_valid <= 1'b1;
						ea_is_mem <= 1'b0;
						ea_addr <= mem_addr;
						br_valid <= 1'b1;
						br_target <= align(mem_rdata[23:0], 1'b1);
					end
				end
				default: ea_q <= CAG_EA_IDLE;
			endcase
			if (state_d == CAG_ST_RESET) begin
				ea_q <= CAG_EA_IDLE;
				mem_rd_req <= 1'b0;
			end
			dec_ready <= (state_d == CAG_ST_EXEC) && (ea_q == CAG_EA_IDLE) &&
				!(take && ea_mode == CAG_M_MEMIND && legal);
		end
	end

endmodule
`default_nettype wire

// ==== rtl/cag_cfg.svh ====
`ifndef CAG_CFG_SVH
`define CAG_CFG_SVH
// Instruction word field positions
`define CAG_OPC_HI 15
`define CAG_OPC_LO 12
`define CAG_CC_HI 11
`define CAG_CC_LO 8
`define CAG_AREG_HI 6
`define CAG_AREG_LO 4
`define CAG_DREG_HI 3
`define CAG_DREG_LO 0
`define CAG_BITN_HI 6
`define CAG_BITN_LO 4
`define CAG_TRAP_HI 5
`define CAG_TRAP_LO 4
// Address space
`define CAG_AW 24
`define CAG_ABS8_FILL 16'hFFFF
`define CAG_PROG_UPPER 8'h00
// Access size steps
`define CAG_STEP_B 24'h000001
`define CAG_STEP_W 24'h000002
`define CAG_STEP_L 24'h000004
// Reset values
`define CAG_RST_ADDR 24'h000000
`define CAG_RST_DATA 32'h00000000
`endif

// ==== rtl/cag_pkg.sv ====
`default_nettype none
package cag_pkg;
	typedef enum logic [4:0] {
		CAG_ST_RESET = 5'h01,
		CAG_ST_EXCEPT = 5'h02,
		CAG_ST_EXEC = 5'h04,
		CAG_ST_BUSREL = 5'h08,
		CAG_ST_STOP = 5'h10
	} cag_state_type;
	typedef enum logic [1:0] {
		CAG_EA_IDLE = 2'h1,
		CAG_EA_INDRD = 2'h2
	} cag_eafsm_type;
	typedef enum logic [3:0] {
		CAG_M_REGDIR = 4'h0,
		CAG_M_REGIND = 4'h1,
		CAG_M_DISP16 = 4'h2,
		CAG_M_DISP32 = 4'h3,
		CAG_M_POSTINC = 4'h4,
		CAG_M_PREDEC = 4'h5,
		CAG_M_ABS8 = 4'h6,
		CAG_M_ABS16 = 4'h7,
		CAG_M_ABS24 = 4'h8,
		CAG_M_ABS32 = 4'h9,
		CAG_M_IMM8 = 4'hA,
		CAG_M_IMM16 = 4'hB,
		CAG_M_IMM32 = 4'hC,
		CAG_M_PCREL8 = 4'hD,
		CAG_M_PCREL16 = 4'hE,
		CAG_M_MEMIND = 4'hF
	} cag_mode_type;
	typedef enum logic [1:0] {
		CAG_SZ_BYTE = 2'h0,
		CAG_SZ_WORD = 2'h1,
		CAG_SZ_LONG = 2'h2
	} cag_size_type;
	typedef enum logic [1:0] {
		CAG_IC_ALU = 2'h0,
		CAG_IC_XFER = 2'h1,
		CAG_IC_BIT = 2'h2,
		CAG_IC_BRANCH = 2'h3
	} cag_class_type;
endpackage
`default_nettype wire

// ==== bench/cag_core_properties.sv ====
`default_nettype none
module cag_chk
	import cag_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic res_n,
	input wire logic wdt_ovf,
	input wire logic exc_req,
	input wire logic dec_valid,
	input wire logic dec_ready,
	input wire cag_mode_type ea_mode,
	input wire cag_size_type acc_size,
	input wire cag_class_type instr_class,
	input wire logic [31:0] gpr_rd_data,
	input wire logic [31:0] ext_data,
	input wire logic mem_rvalid,
	input wire logic [31:0] mem_rdata,
	input wire cag_state_type cpu_state,
	input wire logic int_mask,
	input wire logic bus_grant,
	input wire logic ea_err,
	input wire logic [23:0] ea_addr,
	input wire logic wb_en,
	input wire logic [31:0] wb_data,
	input wire logic br_valid,
	input wire logic [23:0] br_target
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Decode counts only with no higher-priority event pending
	wire logic take = ce && dec_valid && dec_ready && !exc_req && res_n
		&& !wdt_ovf && cpu_state == CAG_ST_EXEC;
	// Even addresses only, so alignment cannot mask the extension
	wire logic xfer = take && instr_class == CAG_IC_XFER && !ext_data[0];
	reset_mask_a:
	assert property (cpu_state == CAG_ST_RESET |-> int_mask)
		else $error("interrupts open in reset");
	pin_reset_a:
	assert property (ce && !res_n |=> cpu_state == CAG_ST_RESET)
		else $error("reset pin ignored");
	wdt_reset_a:
	assert property (ce && wdt_ovf |=> cpu_state == CAG_ST_RESET)
		else $error("watchdog ignored");
	grant_state_a:
	assert property (bus_grant |-> cpu_state == CAG_ST_BUSREL)
		else $error("grant outside release");
	vec_branch_a:
	assert property (ce && mem_rvalid && cpu_state == CAG_ST_EXCEPT
		|=> br_valid && br_target == {$past(mem_rdata[23:1]), 1'b0})
		else $error("vector target wrong");
	abs8_fill_a:
	assert property (xfer && ea_mode == CAG_M_ABS8
		|=> ea_addr == {16'hFFFF, $past(ext_data[7:0])})
		else $error("abs8 not filled");
	abs16_sext_a:
	assert property (xfer && ea_mode == CAG_M_ABS16
		|=> ea_addr == {{8{$past(ext_data[15])}}, $past(ext_data[15:0])})
		else $error("abs16 not extended");
	alu_mode_err_a:
	assert property (take && instr_class == CAG_IC_ALU
		&& ea_mode == CAG_M_ABS32 |=> ea_err && !wb_en)
		else $error("illegal mode accepted");
	postinc_step_a:
	assert property (xfer && ea_mode == CAG_M_POSTINC
		&& acc_size == CAG_SZ_LONG |=> wb_en
		&& wb_data[23:0] == $past(gpr_rd_data[23:0]) + 24'h000004)
		else $error("post increment wrong");
	cover property (take && ea_mode == CAG_M_MEMIND);
	cover property (bus_grant);
	cover property (cpu_state == CAG_ST_STOP);
endmodule
bind cag_core cag_chk u_chk (.*);
`default_nettype wire

// ==== bench/cag_mem_model.sv ====
`default_nettype none
module cag_mem_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] lat,
	input wire logic mem_rd_req,
	input wire logic [23:0] mem_addr,
	output logic mem_rvalid,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] wait_q;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wait_q <= 4'h0;
			mem_rvalid <= 1'b0;
			mem_rdata <= 32'h00000000;
		end else if (mem_rd_req && !mem_rvalid && wait_q == lat) begin
			// Nonzero top byte that a target must drop
			wait_q <= 4'h0;
			mem_rvalid <= 1'b1;
			mem_rdata <= {8'hC3, mem_addr ^ 24'h0F0F13};
		end else begin
			// Stale data toggles so nothing can latch it late
			wait_q <= (mem_rd_req && !mem_rvalid) ? wait_q + 4'h1 : 4'h0;
			mem_rvalid <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule
`default_nettype wire

// ==== bench/tb_cpu_address_gen_and_states.sv ====
`default_nettype none
module tb_cpu_address_gen_and_states;
	import cag_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'h0, rst = 1'h1, ce = 1'h1, res_n = 1'h0;
	logic wdt_ovf = 1'h0, exc_req = 1'h0, bus_req = 1'h0;
	logic sleep_exec = 1'h0, hw_standby = 1'h0, dec_valid = 1'h0;
	logic [23:0] exc_vec_addr = 24'h000010, next_pc = 24'h001000;
	logic [15:0] op_word = 16'hA5C3;
	logic [31:0] ext_data = 32'h0, gpr_rd_data = 32'h0;
	logic [3:0] lat = 4'h0;
	cag_mode_type ea_mode = CAG_M_REGDIR;
	cag_size_type acc_size = CAG_SZ_BYTE;
	cag_class_type instr_class = CAG_IC_ALU;
	cag_state_type cpu_state;
	logic int_mask, bus_grant, dec_ready, ea_valid, ea_err, ea_is_mem;
	logic wb_en, br_valid, mem_rd_req, mem_rvalid;
	logic [23:0] ea_addr, br_target, mem_addr;
	logic [31:0] opnd_data, wb_data, mem_rdata;
	logic [3:0] opcode, cond_code, dreg_idx;
	logic [2:0] areg_idx, bit_num, wb_idx;
	logic [1:0] trap_vec;
	int err_total = 0, checks_done = 0, cyc = 0;
	cag_core u_dut (.*);
	cag_mem_model u_mem (.*);
	always #10 clk_sys = ~clk_sys;
	function automatic logic [23:0] tgt(input logic [23:0] a);
		return (a ^ 24'h0F0F13) & 24'hFFFFFE;
	endfunction
	task automatic chk(input string nm, input logic [63:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic dec(input cag_mode_type m, input cag_class_type c,
			input cag_size_type s, input logic [31:0] g, x);
		@(negedge clk_sys);
		ea_mode = m;
		instr_class = c;
		acc_size = s;
		gpr_rd_data = g;
		ext_data = x;
		dec_valid = 1'h1;
		@(negedge clk_sys);
		dec_valid = 1'h0;
	endtask
	task automatic wait_br;
		for (int n = 0; n < 40 && br_valid !== 1'h1; n++)
			@(negedge clk_sys);
		chk("br_valid", br_valid, 1'h1);
	endtask
	task automatic t_boot;
		chk("reset", {int_mask, cpu_state}, {1'h1, CAG_ST_RESET});
		res_n = 1'h1;
		wait_br();
		chk("vector", br_target, tgt(exc_vec_addr));
		chk("exec", cpu_state, CAG_ST_EXEC);
	endtask
	task automatic t_data;
		dec(CAG_M_ABS8, CAG_IC_XFER, CAG_SZ_BYTE, 32'h0, 32'h00000080);
		chk("abs8", {ea_is_mem, ea_addr}, {1'h1, 24'hFFFF80});
		chk("fields", {opcode, cond_code, areg_idx, dreg_idx, bit_num},
			{4'hA, 4'h5, 3'h4, 4'h3, 3'h4});
		dec(CAG_M_REGDIR, CAG_IC_ALU, CAG_SZ_BYTE, 32'h12345678, 32'h0);
		chk("regdir", {ea_is_mem, opnd_data}, {1'h0, 32'h00000056});
		dec(CAG_M_IMM16, CAG_IC_ALU, CAG_SZ_WORD, 32'h0, 32'hABCD1234);
		chk("imm16", {ea_is_mem, opnd_data}, {1'h0, 32'h00001234});
		dec(CAG_M_DISP32, CAG_IC_XFER, CAG_SZ_BYTE, 32'h00FFFFF0, 32'h21);
		chk("disp32", ea_addr, 24'h000011);
		dec(CAG_M_ABS16, CAG_IC_XFER, CAG_SZ_WORD, 32'h0, 32'h00008002);
		chk("abs16", ea_addr, 24'hFF8002);
		dec(CAG_M_DISP16, CAG_IC_XFER, CAG_SZ_LONG, 32'h10, 32'h0000FFF0);
		chk("disp16", ea_addr, 24'h000000);
		dec(CAG_M_POSTINC, CAG_IC_XFER, CAG_SZ_LONG, 32'h55FFFFFE, 32'h0);
		chk("postinc", {ea_addr, wb_data, wb_idx},
			{24'hFFFFFE, 32'h55000002, 3'h4});
		dec(CAG_M_PREDEC, CAG_IC_XFER, CAG_SZ_WORD, 32'h1, 32'h0);
		chk("predec", {ea_addr, wb_data}, {24'hFFFFFE, 32'hFFFFFF});
		dec(CAG_M_ABS32, CAG_IC_ALU, CAG_SZ_LONG, 32'h0, 32'h1);
		chk("alu_err", {ea_valid, ea_err, wb_en}, 3'h6);
		dec(CAG_M_PCREL8, CAG_IC_XFER, CAG_SZ_BYTE, 32'h0, 32'h0);
		chk("xfer_err", ea_err, 1'h1);
	endtask
	task automatic t_branch;
		dec(CAG_M_PCREL16, CAG_IC_BRANCH, CAG_SZ_WORD, 32'h0, 32'h8001);
		chk("pcrel16", br_target, 24'hFF9000);
		op_word = 16'h00FF;
		dec(CAG_M_PCREL8, CAG_IC_BRANCH, CAG_SZ_WORD, 32'h0, 32'h0);
		chk("pcrel8", br_target, 24'h000FFE);
		chk("fields2", {dreg_idx, bit_num, trap_vec}, {4'hF, 3'h7, 2'h3});
		dec(CAG_M_ABS24, CAG_IC_BRANCH, CAG_SZ_LONG, 32'h0, 32'h12345677);
		chk("abs24", br_target, 24'h345676);
		dec(CAG_M_REGIND, CAG_IC_BRANCH, CAG_SZ_LONG, 32'hAB000101, 32'h0);
		chk("regind", br_target, 24'h000100);
		// Slow memory keeps the indirect read open
		lat = 4'h5;
		dec(CAG_M_MEMIND, CAG_IC_BRANCH, CAG_SZ_LONG, 32'h0, 32'h140);
		chk("ind_addr", mem_addr, 24'h000040);
		chk("ind_busy", {dec_ready, mem_rd_req}, 2'h1);
		wait_br();
		chk("memind", br_target, tgt(24'h000040));
	endtask
	task automatic t_states;
		@(negedge clk_sys);
		bus_req = 1'h1;
		ce = 1'h0;
		repeat (2) @(negedge clk_sys);
		// Frozen clock enable must hold off the release
		chk("freeze", {bus_grant, cpu_state}, {1'h0, CAG_ST_EXEC});
		ce = 1'h1;
		repeat (3) @(negedge clk_sys);
		chk("grant", {bus_grant, cpu_state}, {1'h1, CAG_ST_BUSREL});
		bus_req = 1'h0;
		repeat (2) @(negedge clk_sys);
		chk("return", {bus_grant, cpu_state}, {1'h0, CAG_ST_EXEC});
		exc_vec_addr = 24'h000024;
		sleep_exec = 1'h1;
		@(negedge clk_sys);
		sleep_exec = 1'h0;
		chk("sleep", cpu_state, CAG_ST_STOP);
		exc_req = 1'h1;
		@(negedge clk_sys);
		exc_req = 1'h0;
		wait_br();
		chk("trap", br_target, tgt(24'h000024));
		hw_standby = 1'h1;
		@(negedge clk_sys);
		chk("standby", cpu_state, CAG_ST_STOP);
		wdt_ovf = 1'h1;
		@(negedge clk_sys);
		wdt_ovf = 1'h0;
		hw_standby = 1'h0;
		chk("wdt", {int_mask, cpu_state}, {1'h1, CAG_ST_RESET});
	endtask
	initial begin
		repeat (12) @(negedge clk_sys);
		rst = 1'h0;
		@(negedge clk_sys);
		t_boot();
		t_data();
		t_branch();
		t_states();
		summarize();
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			summarize();
		end
	end
endmodule
`default_nettype wire
